// >>> core/tone_transceiver_host_regs.sv
`timescale 1ns/1ps
`default_nettype none

module tone_transceiver_host_regs
  import tone_xcvr_pkg::*;
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic arst_n_i,
  // Mode and power pins
  input wire logic bus_style_sel_i,
  input wire logic power_down_pin_i,
  // Processor port strobes
  input wire logic chip_sel_n_i,
  input wire logic wr_n_i,
  input wire logic rd_n_i,
  input wire logic ale_i,
  input wire logic [1:0] addr_i,
  // Processor data lines
  input wire logic [3:0] data_i,
  output logic [3:0] data_o,
  output logic data_oe_o,
  // Detector inputs
  input wire logic dtmf_present_n_i,
  input wire logic [3:0] rx_code_i,
  input wire logic fax_tone_i,
  input wire logic progress_tone_i,
  // Detector pins
  output logic fax_detect_pin_o,
  output logic progress_detect_pin_o,
  // Generator controls
  output logic tone_pair_tx_on_o,
  output logic progress_tone_tx_on_o,
  output logic fast_detect_sel_o,
  output logic [HZ_W-1:0] tone_low_hz_o,
  output logic [HZ_W-1:0] tone_high_hz_o,
  output logic [HZ_W-1:0] rx_low_hz_o,
  output logic [HZ_W-1:0] rx_high_hz_o
);

  // ---------------------------------------------------------------
  // Helper functions
  // ---------------------------------------------------------------
  // Readable selects have the low bit set
  function automatic logic is_readable(input logic [1:0] sel);
    is_readable = sel[SEL_READ_BIT];
  endfunction : is_readable

  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  logic [3:0] tx_digit_code;    // Written transmit code
  logic [3:0] control_word;     // Written control bits
  logic [3:0] rx_digit_code;    // Last received code
  logic [3:0] active_code;      // Code feeding the generator
  logic detect_event_flag;      // Onset flag, cleared by status read or when all detectors go quiet
  logic dtmf_present_n;         // Registered DTMF absent level
  logic wr_n_q;                 // Previous write strobe
  logic rd_n_q;                 // Previous read strobe
  logic [1:0] rd_sel;           // Register picked for reading
  access_state_t acc_state;     // Read access state

  // Combinational
  access_state_t next_state;
  logic [1:0] next_rd_sel;
  logic read_done;              // A read access ends this cycle
  logic wr_rise, rd_fall, rd_rise;  // Strobe edges
  logic write_hit;
  logic [1:0] write_sel;
  logic next_fax, next_progress;  // Gated detector levels
  logic set_event, clear_event;  // Flag set and clear terms
  logic [3:0] status_nibble;
  logic [3:0] lut_code [2];
  logic [HZ_W-1:0] lut_low [2], lut_high [2];  // Lookup results

  // ---------------------------------------------------------------
  // Strobe edge detection
  // ---------------------------------------------------------------
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wr_n_q <= 1'b1;
      rd_n_q <= 1'b1;
    end else begin
      wr_n_q <= wr_n_i;
      rd_n_q <= rd_n_i;
    end
  end

  assign wr_rise = wr_n_i & ~wr_n_q;
  assign rd_fall = ~rd_n_i & rd_n_q;
  assign rd_rise = rd_n_i & ~rd_n_q;

  // Separate style uses address lines, combined style uses ALE
  always_comb begin
    write_hit = 1'b0;
    write_sel = SEL_TX_CODE;
    if (bus_style_sel_i) begin
      write_hit = ~chip_sel_n_i & wr_rise;
      write_sel = addr_i;
    end else begin
      write_hit = ~chip_sel_n_i & ~wr_n_i & rd_fall;
      write_sel = {ale_i, 1'b0};
    end
  end

  // ---------------------------------------------------------------
  // Written registers
  // ---------------------------------------------------------------
  // Power-down holds both registers at reset value
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tx_digit_code <= TX_CODE_RST;
      control_word <= CONTROL_RST;
    end else if (power_down_pin_i) begin
      tx_digit_code <= TX_CODE_RST;
      control_word <= CONTROL_RST;
    end else if (write_hit) begin
      // Selects 1 and 3 are read-only and ignored here
      if (write_sel == SEL_TX_CODE) begin
        tx_digit_code <= data_i;
      end
      if (write_sel == SEL_CONTROL) begin
        control_word <= data_i;
      end
    end
  end

  // ---------------------------------------------------------------
  // Read access state machine
  // ---------------------------------------------------------------
  always_comb begin
    next_state = acc_state;
    next_rd_sel = rd_sel;
    read_done = 1'b0;
    case (acc_state)
      ACC_IDLE: begin
        if (bus_style_sel_i && !chip_sel_n_i && !rd_n_i) begin
          next_state = ACC_SPLIT_READ;
          next_rd_sel = addr_i;
        end else if (!bus_style_sel_i && !chip_sel_n_i && wr_n_i &&
                     rd_rise) begin
          next_state = ACC_SHARED_READ;
          next_rd_sel = {ale_i, 1'b1};
        end
      end
      ACC_SPLIT_READ: begin
        if (bus_style_sel_i && !chip_sel_n_i && !rd_n_i) begin
          next_rd_sel = addr_i;
        end else begin
          next_state = ACC_IDLE;
          read_done = 1'b1;
        end
      end
      ACC_SHARED_READ: begin
        // Data phase ends on the next falling read strobe
        if (bus_style_sel_i || chip_sel_n_i || !wr_n_i || !rd_n_i) begin
          next_state = ACC_IDLE;
          read_done = 1'b1;
        end
      end
      default: begin
        next_state = ACC_IDLE;
      end
    endcase
  end

  // State and select registers
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      acc_state <= ACC_IDLE;
      rd_sel <= SEL_TX_CODE;
    end else begin
      acc_state <= next_state;
      rd_sel <= next_rd_sel;
    end
  end

  // Write-only selects never enable the driver
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      data_o <= DATA_RST;
      data_oe_o <= 1'b0;
    end else begin
      data_oe_o <= (next_state != ACC_IDLE) && is_readable(next_rd_sel);
      if (next_rd_sel == SEL_STATUS) begin
        data_o <= status_nibble;
      end else if (next_rd_sel == SEL_RX_CODE) begin
        data_o <= rx_digit_code;
      end else begin
        data_o <= DATA_RST;
      end
    end
  end

  // ---------------------------------------------------------------
  // Detector status
  // ---------------------------------------------------------------
  // Gate and forcing applied before registering
  assign next_progress = control_word[CTL_AUX_DETECT_EN] &
                         progress_tone_i;
  assign next_fax = control_word[CTL_AUX_DETECT_EN] & fax_tone_i &
                    ~next_progress;
  assign status_nibble = {dtmf_present_n, fax_detect_pin_o,
                          progress_detect_pin_o, detect_event_flag};

  // Pins double as the status bits
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      dtmf_present_n <= 1'b1;
      fax_detect_pin_o <= 1'b0;
      progress_detect_pin_o <= 1'b0;
    end else begin
      dtmf_present_n <= dtmf_present_n_i;
      fax_detect_pin_o <= next_fax;
      progress_detect_pin_o <= next_progress;
    end
  end

  // Receive code captured while a valid digit is present
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rx_digit_code <= RX_CODE_RST;
    end else if (!dtmf_present_n_i) begin
      rx_digit_code <= rx_code_i;
    end
  end

  assign set_event = (dtmf_present_n & ~dtmf_present_n_i) |
                     (~fax_detect_pin_o & next_fax) |
                     (~progress_detect_pin_o & next_progress);
  assign clear_event = (read_done && rd_sel == SEL_STATUS) ||
                       (dtmf_present_n_i && !next_fax &&
                        !next_progress);

  // Onset wins over a clear in the same cycle
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      detect_event_flag <= 1'b0;
    end else if (set_event) begin
      detect_event_flag <= 1'b1;
    end else if (clear_event) begin
      detect_event_flag <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Tone generator controls
  // ---------------------------------------------------------------
  // Active code freezes while tone-pair output is on
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      active_code <= TX_CODE_RST;
    end else if (!control_word[CTL_TONE_PAIR_TX_ON]) begin
      active_code <= tx_digit_code;
    end
  end

  // One lookup for transmit, one for receive
  assign lut_code[0] = active_code;
  assign lut_code[1] = rx_digit_code;
  for (genvar i = 0; i < 2; i++) begin : g_lut
    tone_pair_lut u_lut (
      .code_i(lut_code[i]),
      .low_hz_o(lut_low[i]),
      .high_hz_o(lut_high[i])
    );
  end

  // Registered frequencies and gating levels
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tone_low_hz_o <= LOW_941;
      tone_high_hz_o <= HIGH_1633;
      rx_low_hz_o <= LOW_941;
      rx_high_hz_o <= HIGH_1633;
      tone_pair_tx_on_o <= 1'b0;
      progress_tone_tx_on_o <= 1'b0;
      fast_detect_sel_o <= 1'b0;
    end else begin
      if (!control_word[CTL_TONE_PAIR_TX_ON]) begin
        tone_low_hz_o <= lut_low[0];
        tone_high_hz_o <= lut_high[0];
      end
      rx_low_hz_o <= lut_low[1];
      rx_high_hz_o <= lut_high[1];
      tone_pair_tx_on_o <= control_word[CTL_TONE_PAIR_TX_ON];
      progress_tone_tx_on_o <= control_word[CTL_PROGRESS_TX_ON];
      fast_detect_sel_o <= control_word[CTL_FAST_DETECT];
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);

  sequence s_split_rx_read;
    bus_style_sel_i && !chip_sel_n_i && !rd_n_i && addr_i == SEL_RX_CODE;
  endsequence
  sequence s_status_read_end;
    read_done && rd_sel == SEL_STATUS && !set_event;
  endsequence

  a_split_write_tx: assert property (
    bus_style_sel_i && !chip_sel_n_i && wr_rise && !power_down_pin_i &&
    addr_i == SEL_TX_CODE |=> tx_digit_code == $past(data_i))
    else $error("tx code not written on write strobe rise");
  a_shared_write_ctl: assert property (
    !bus_style_sel_i && !chip_sel_n_i && !wr_n_i && rd_fall && ale_i &&
    !power_down_pin_i |=> control_word == $past(data_i))
    else $error("control not written on read strobe fall");
  a_power_down_clear: assert property (
    power_down_pin_i |=> tx_digit_code == TX_CODE_RST &&
    control_word == CONTROL_RST)
    else $error("power-down did not clear registers");
  a_write_only_hidden: assert property (
    bus_style_sel_i && !chip_sel_n_i && !rd_n_i &&
    !is_readable(addr_i) |=> !data_oe_o)
    else $error("write-only register driven on data lines");
  a_split_read_drive: assert property (
    s_split_rx_read ##1 s_split_rx_read |->
    data_oe_o && data_o == $past(rx_digit_code))
    else $error("receive code not driven during read");
  a_tone_freeze: assert property (
    $past(control_word[CTL_TONE_PAIR_TX_ON]) |->
    $stable(tone_low_hz_o) && $stable(tone_high_hz_o))
    else $error("tone pair changed while transmitting");
  a_gate_holds_low: assert property (
    !control_word[CTL_AUX_DETECT_EN] |=>
    !fax_detect_pin_o && !progress_detect_pin_o)
    else $error("gated detector pin not low");
  a_fax_forced_low: assert property (
    progress_detect_pin_o |-> !fax_detect_pin_o)
    else $error("fax bit high during progress tone");
  a_event_onset: assert property (
    set_event |=> detect_event_flag [*1] ##1 1'b1)
    else $error("event flag not set on onset");
  a_read_clears: assert property (
    s_status_read_end |=> !detect_event_flag)
    else $error("event flag not cleared after status read");

endmodule : tone_transceiver_host_regs

`default_nettype wire

// >>> core/tone_xcvr_pkg.sv
package tone_xcvr_pkg;

  // ---------------------------------------------------------------
  // Register selects (two-bit register index)
  // ---------------------------------------------------------------
  localparam logic [1:0] SEL_TX_CODE = 2'h0;  // Transmit digit code
  localparam logic [1:0] SEL_RX_CODE = 2'h1;  // Receive digit code
  localparam logic [1:0] SEL_CONTROL = 2'h2;  // Control word
  localparam logic [1:0] SEL_STATUS = 2'h3;   // Status nibble
  localparam int SEL_READ_BIT = 0;            // Set on readable selects

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int CTL_TONE_PAIR_TX_ON = 0;     // Tone-pair output on
  localparam int CTL_AUX_DETECT_EN = 1;       // Progress/fax gate
  localparam int CTL_FAST_DETECT = 2;         // High-speed detect
  localparam int CTL_PROGRESS_TX_ON = 3;      // Progress tone on
  localparam int STS_EVENT = 0;               // Detect-event flag
  localparam int STS_PROGRESS = 1;            // Progress tone present
  localparam int STS_FAX = 2;                 // Fax tone present
  localparam int STS_DTMF_N = 3;              // Active-low DTMF present

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [3:0] TX_CODE_RST = 4'h0;
  localparam logic [3:0] CONTROL_RST = 4'h0;
  localparam logic [3:0] RX_CODE_RST = 4'h0;
  localparam logic [3:0] DATA_RST = 4'h0;

  // ---------------------------------------------------------------
  // Tone frequencies in Hz
  // ---------------------------------------------------------------
  localparam int HZ_W = 11;
  localparam logic [HZ_W-1:0] LOW_697 = 11'h2b9;
  localparam logic [HZ_W-1:0] LOW_770 = 11'h302;
  localparam logic [HZ_W-1:0] LOW_852 = 11'h354;
  localparam logic [HZ_W-1:0] LOW_941 = 11'h3ad;
  localparam logic [HZ_W-1:0] HIGH_1209 = 11'h4b9;
  localparam logic [HZ_W-1:0] HIGH_1336 = 11'h538;
  localparam logic [HZ_W-1:0] HIGH_1477 = 11'h5c5;
  localparam logic [HZ_W-1:0] HIGH_1633 = 11'h661;

  // ---------------------------------------------------------------
  // Access state encoding
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ACC_IDLE = 2'b00,        // No read in progress
    ACC_SPLIT_READ = 2'b01,  // Separate-strobe read, strobe low
    ACC_SHARED_READ = 2'b10  // Combined-strobe read data phase
  } access_state_t;

endpackage : tone_xcvr_pkg

// >>> core/tone_pair_lut.sv
`timescale 1ns/1ps
`default_nettype none

module tone_pair_lut
  import tone_xcvr_pkg::*;
(
  // Digit code in
  input wire logic [3:0] code_i,
  // Tone pair out
  output logic [HZ_W-1:0] low_hz_o,
  output logic [HZ_W-1:0] high_hz_o
);

  // ---------------------------------------------------------------
  // Code to low/high group frequency
  // ---------------------------------------------------------------
  always_comb begin
    case (code_i)
      4'h1: begin low_hz_o = LOW_697; high_hz_o = HIGH_1209; end
      4'h2: begin low_hz_o = LOW_697; high_hz_o = HIGH_1336; end
      4'h3: begin low_hz_o = LOW_697; high_hz_o = HIGH_1477; end
      4'h4: begin low_hz_o = LOW_770; high_hz_o = HIGH_1209; end
      4'h5: begin low_hz_o = LOW_770; high_hz_o = HIGH_1336; end
      4'h6: begin low_hz_o = LOW_770; high_hz_o = HIGH_1477; end
      4'h7: begin low_hz_o = LOW_852; high_hz_o = HIGH_1209; end
      4'h8: begin low_hz_o = LOW_852; high_hz_o = HIGH_1336; end
      4'h9: begin low_hz_o = LOW_852; high_hz_o = HIGH_1477; end
      4'ha: begin low_hz_o = LOW_941; high_hz_o = HIGH_1336; end
      4'hb: begin low_hz_o = LOW_941; high_hz_o = HIGH_1209; end
      4'hc: begin low_hz_o = LOW_941; high_hz_o = HIGH_1477; end
      4'hd: begin low_hz_o = LOW_697; high_hz_o = HIGH_1633; end
      4'he: begin low_hz_o = LOW_770; high_hz_o = HIGH_1633; end
      4'hf: begin low_hz_o = LOW_852; high_hz_o = HIGH_1633; end
      default: begin low_hz_o = LOW_941; high_hz_o = HIGH_1633; end
    endcase
  end

endmodule : tone_pair_lut

`default_nettype wire

// >>> bench/host_mcu_model.sv
`timescale 1ns/1ps
`default_nettype none

module host_mcu_model (
  // Clock and bus levels
  input wire logic clock_i,
  input wire logic [3:0] bus_i,
  input wire logic oe_i,
  // Pins toward the device
  output logic style_o,
  output logic pd_o,
  output logic cs_n_o,
  output logic wr_n_o,
  output logic rd_n_o,
  output logic ale_o,
  output logic [1:0] addr_o,
  output logic [3:0] data_o,
  output logic drive_o
);
  // ---------------------------------------------------------------
  // Idle pin levels
  // ---------------------------------------------------------------
  initial begin
    style_o = 1'b1;
    pd_o = 1'b1;
    cs_n_o = 1'b1;
    wr_n_o = 1'b1;
    rd_n_o = 1'b1;
    ale_o = 1'b0;
    addr_o = 2'h0;
    data_o = 4'h0;
    drive_o = 1'b0;
  end

  // ---------------------------------------------------------------
  // Bus cycles
  // ---------------------------------------------------------------
  // Pins change just after the rising edge
  task step;
    @(posedge clock_i);
    #1;
  endtask : step

  // Power-on hold of the power-down pin
  task power_up(input int n);
    pd_o = 1'b1;
    repeat (n) step();
    pd_o = 1'b0;
    step();
  endtask : power_up

  // Nibble write in either strobe style
  task write_reg(input logic [1:0] sel, input logic [3:0] val);
    cs_n_o = 1'b0;
    addr_o = sel;
    ale_o = sel[1];
    data_o = val;
    drive_o = 1'b1;
    wr_n_o = 1'b0;
    step();
    if (style_o) begin
      wr_n_o = 1'b1;
    end else begin
      rd_n_o = 1'b0;
    end
    step();
    cs_n_o = 1'b1;
    rd_n_o = 1'b1;
    wr_n_o = 1'b1;
    drive_o = 1'b0;
    step();
  endtask : write_reg

  // Nibble read; lines released while the device drives
  task read_reg(input logic [1:0] sel, output logic [3:0] val,
                output logic oe);
    cs_n_o = 1'b0;
    addr_o = sel;
    ale_o = sel[1];
    wr_n_o = 1'b1;
    rd_n_o = 1'b0;
    step();
    if (!style_o) begin
      rd_n_o = 1'b1;
    end
    repeat (3) step();
    val = bus_i;
    oe = oe_i;
    rd_n_o = style_o;
    step();
    rd_n_o = 1'b1;
    cs_n_o = 1'b1;
    repeat (2) step();
  endtask : read_reg
endmodule : host_mcu_model

`default_nettype wire

// >>> bench/tone_transceiver_host_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none

module tone_transceiver_host_regs_tb;
  import tone_xcvr_pkg::*;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic clock_i, arst_n_i, style, pd, cs_n, wr_n, rd_n, ale, drive;
  logic [1:0] addr;
  logic [3:0] mcu_data, bus, data_o, float_pat, rx_code;
  logic data_oe, dtmf_n, fax, prog, fax_pin, prog_pin;
  logic pair_on, prog_on, fast;
  logic [HZ_W-1:0] tx_lo, tx_hi, rx_lo, rx_hi;
  int err_total, checks_done;

  // Clock at 125 MHz
  initial begin
    clock_i = 1'b0;
    forever #4 clock_i = ~clock_i;
  end
  // Undriven lines change every cycle
  always @(posedge clock_i) float_pat <= ~float_pat;
  assign bus = data_oe ? data_o : (drive ? mcu_data : float_pat);

  tone_transceiver_host_regs uut (.clock_i(clock_i), .arst_n_i(arst_n_i),
    .bus_style_sel_i(style), .power_down_pin_i(pd), .chip_sel_n_i(cs_n),
    .wr_n_i(wr_n), .rd_n_i(rd_n), .ale_i(ale), .addr_i(addr),
    .data_i(bus), .data_o(data_o), .data_oe_o(data_oe),
    .dtmf_present_n_i(dtmf_n), .rx_code_i(rx_code), .fax_tone_i(fax),
    .progress_tone_i(prog), .fax_detect_pin_o(fax_pin),
    .progress_detect_pin_o(prog_pin), .tone_pair_tx_on_o(pair_on),
    .progress_tone_tx_on_o(prog_on), .fast_detect_sel_o(fast),
    .tone_low_hz_o(tx_lo), .tone_high_hz_o(tx_hi),
    .rx_low_hz_o(rx_lo), .rx_high_hz_o(rx_hi));

  host_mcu_model mcu (.clock_i(clock_i), .bus_i(bus), .oe_i(data_oe),
    .style_o(style), .pd_o(pd), .cs_n_o(cs_n), .wr_n_o(wr_n),
    .rd_n_o(rd_n), .ale_o(ale), .addr_o(addr), .data_o(mcu_data),
    .drive_o(drive));

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task check(input logic [10:0] seen, input logic [10:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Expected low and high tone of a digit code
  function automatic logic [21:0] pair_of(input logic [3:0] c);
    case (c)
      4'h1: return {LOW_697, HIGH_1209};
      4'h2: return {LOW_697, HIGH_1336};
      4'h3: return {LOW_697, HIGH_1477};
      4'h4: return {LOW_770, HIGH_1209};
      4'h5: return {LOW_770, HIGH_1336};
      4'h6: return {LOW_770, HIGH_1477};
      4'h7: return {LOW_852, HIGH_1209};
      4'h8: return {LOW_852, HIGH_1336};
      4'h9: return {LOW_852, HIGH_1477};
      4'ha: return {LOW_941, HIGH_1336};
      4'hb: return {LOW_941, HIGH_1209};
      4'hc: return {LOW_941, HIGH_1477};
      4'hd: return {LOW_697, HIGH_1633};
      4'he: return {LOW_770, HIGH_1633};
      4'hf: return {LOW_852, HIGH_1633};
      default: return {LOW_941, HIGH_1633};
    endcase
  endfunction : pair_of

  task settle;
    repeat (3) mcu.step();
  endtask : settle

  // Read and compare one readable register
  task rd_chk(input logic [1:0] sel, input logic [3:0] exp);
    logic [3:0] v;
    logic oe;
    mcu.read_reg(sel, v, oe);
    check({10'h0, oe}, 11'h1);
    check({7'h0, v}, {7'h0, exp});
  endtask : rd_chk

  task tx_chk(input logic [3:0] c);
    logic [21:0] p;
    p = pair_of(c);
    check(tx_lo, p[21:11]);
    check(tx_hi, p[10:0]);
  endtask : tx_chk

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  // Every code, both styles, transmit and receive mapping
  task test_codes;
    logic [21:0] p;
    for (int c = 0; c < 16; c++) begin
      mcu.style_o = c[0];
      rx_code = 4'(15 - c);
      dtmf_n = 1'b0;
      mcu.write_reg(SEL_TX_CODE, 4'(c));
      settle();
      tx_chk(4'(c));
      p = pair_of(4'(15 - c));
      check(rx_lo, p[21:11]);
      check(rx_hi, p[10:0]);
      rd_chk(SEL_RX_CODE, 4'(15 - c));
    end
    dtmf_n = 1'b1;
    mcu.style_o = 1'b1;
  endtask : test_codes

  // Each control bit alone
  task test_control;
    logic [3:0] v;
    for (int i = 0; i < 4; i++) begin
      v = 4'h1 << i;
      mcu.style_o = i[0];
      mcu.write_reg(SEL_CONTROL, v);
      settle();
      check({10'h0, pair_on}, {10'h0, v[0]});
      check({10'h0, fast}, {10'h0, v[2]});
      check({10'h0, prog_on}, {10'h0, v[3]});
    end
    mcu.style_o = 1'b1;
  endtask : test_control

  // Code change while sending keeps the tone pair
  task test_freeze;
    mcu.write_reg(SEL_CONTROL, 4'h0);
    mcu.write_reg(SEL_TX_CODE, 4'h5);
    mcu.write_reg(SEL_CONTROL, 4'h1);
    mcu.write_reg(SEL_TX_CODE, 4'h9);
    settle();
    tx_chk(4'h5);
    mcu.write_reg(SEL_CONTROL, 4'h0);
    settle();
    tx_chk(4'h9);
  endtask : test_freeze

  // Separate style: write-only selects never driven; combined style:
  // direction high always reaches receive code or status
  task test_wo;
    logic [3:0] v;
    logic oe;
    for (int i = 0; i < 4; i++) begin
      mcu.style_o = i[1];
      mcu.read_reg({i[0], 1'b0}, v, oe);
      check({10'h0, oe}, {10'h0, ~i[1]});
      if (!i[1]) begin
        check({7'h0, v}, i[0] ? 11'h8 : 11'h0);
      end
    end
    mcu.style_o = 1'b1;
  endtask : test_wo

  // Power-down clears code and control, refuses writes
  task test_pd;
    mcu.write_reg(SEL_TX_CODE, 4'h3);
    mcu.write_reg(SEL_CONTROL, 4'hd);
    mcu.pd_o = 1'b1;
    mcu.write_reg(SEL_TX_CODE, 4'h7);
    mcu.pd_o = 1'b0;
    settle();
    check({10'h0, pair_on}, 11'h0);
    check({10'h0, prog_on}, 11'h0);
    tx_chk(4'h0);
  endtask : test_pd

  // Detector gating, status bits and the event flag
  task test_detect;
    fax = 1'b1;
    prog = 1'b1;
    settle();
    check({9'h0, fax_pin, prog_pin}, 11'h0);
    rd_chk(SEL_STATUS, 4'h8);
    mcu.write_reg(SEL_CONTROL, 4'h2);
    settle();
    check({9'h0, fax_pin, prog_pin}, 11'h1);
    rd_chk(SEL_STATUS, 4'hb);
    rd_chk(SEL_STATUS, 4'ha);
    prog = 1'b0;
    settle();
    check({9'h0, fax_pin, prog_pin}, 11'h2);
    rd_chk(SEL_STATUS, 4'hd);
    rd_chk(SEL_STATUS, 4'hc);
    fax = 1'b0;
    dtmf_n = 1'b0;
    settle();
    rd_chk(SEL_STATUS, 4'h1);
    rd_chk(SEL_STATUS, 4'h0);
    dtmf_n = 1'b1;
    settle();
    dtmf_n = 1'b0;
    settle();
    dtmf_n = 1'b1;
    settle();
    rd_chk(SEL_STATUS, 4'h8);
  endtask : test_detect

  // ---------------------------------------------------------------
  // Verdict and main sequence
  // ---------------------------------------------------------------
  task stop_test;
    if (err_total == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : stop_test

  initial begin
    repeat (40000) @(posedge clock_i);
    err_total++;
    stop_test();
  end

  initial begin
    arst_n_i = 1'b0;
    dtmf_n = 1'b1;
    fax = 1'b0;
    prog = 1'b0;
    rx_code = 4'h0;
    float_pat = 4'h5;
    err_total = 0;
    checks_done = 0;
    repeat (16) @(posedge clock_i);
    #1 arst_n_i = 1'b1;
    mcu.power_up(25000);
    tx_chk(4'h0);
    rd_chk(SEL_STATUS, 4'h8);
    test_codes();
    test_control();
    test_freeze();
    test_wo();
    test_pd();
    test_detect();
    stop_test();
  end
endmodule : tone_transceiver_host_regs_tb

`default_nettype wire
